// ---- src/slet_error_monitor.sv ----
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "slet_regs.svh"
// Operation
// [RQ1] Software writes only 1, 2 or 4 multiframe groups; resets to one.
// [RQ2] Alignment sequence spans the programmed count of four-multiframe groups.
// [RQ3] Count disparity, table and control errors against an 8-bit limit, reset 0xFF.
// [RQ4] Reaching the limit raises interrupt, sync request, or both per masks.
// [RQ5] Every active lane counts and compares on its own, sharing one limit.
// [RQ6] Software changes count and limit only while the link is in soft reset.
// [RQ7] Three-bit sync mask, bit 2 disparity, bit 0 control char, reset 7.
// [RQ8] Sync request only for a masked type whose counter reached the limit.
// [RQ9] Lane 0 counter enables: bit 2 control char, bit 0 disparity, reset 7.
// [RQ10] A cleared counter-enable bit stops that counter from counting.
// [RQ11] With auto clear on, the counter that caused sync returns to zero.
// [RQ12] Queued mode off merges simultaneous lane errors; sync pulses one by one.

module slet_error_monitor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SLET_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link receive side, same clock domain.
  input wire logic link_soft_reset,
  input wire logic [`SLET_NUM_LANES-1:0] lane_active,
  input wire logic [`SLET_NUM_LANES-1:0] bad_disparity_error,
  input wire logic [`SLET_NUM_LANES-1:0] not_in_table_error,
  input wire logic [`SLET_NUM_LANES-1:0] unexpected_control_char_error,
  input wire logic ilas_active,
  input wire logic multiframe_tick,
  // Results.
  output logic sync_request_out,
  output logic ilas_done,
  output logic irq
);
  import slet_pkg::*;

  localparam int NL = `SLET_NUM_LANES;
  localparam int NT = `SLET_NUM_TYPES;

  // Register file state.
  slet_count_type error_threshold_q, error_threshold_d;
  logic [NT-1:0] sync_error_type_mask_q, sync_error_type_mask_d;
  logic [NT-1:0] lane0_counter_enables_q, lane0_counter_enables_d;
  logic [7:0] alignment_multiframe_count_q, alignment_multiframe_count_d;
  logic auto_counter_clear_q, auto_counter_clear_d;
  logic queued_error_report_mode_q, queued_error_report_mode_d;
  logic [`SLET_IRQ_W-1:0] irq_status_q, irq_status_d;
  logic [`SLET_IRQ_W-1:0] irq_enable_q, irq_enable_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;

  // Bus decode.
  logic [`SLET_IDX_W-1:0] reg_idx;
  logic bus_access;
  logic bus_write;
  logic addr_hit;
  logic [31:0] read_word;

  // Lane results, flattened lane by lane.
  logic [NL*NT-1:0] lane_match;
  logic [NL*NT-1:0] lane_at_limit;
  logic [NT-1:0] type_match;
  logic [NT-1:0] type_at_limit;
  logic [NT-1:0] mask_by_type;
  logic [NT-1:0] auto_clear_by_type;
  logic [`SLET_PEND_W-1:0] new_events;

  // Alignment sequence counter.
  logic [9:0] mf_count_q, mf_count_d;
  logic [9:0] mf_span;
  logic ilas_done_q, ilas_done_d;

  // Sync request sequencer.
  slet_sync_state_type sync_state_q, sync_state_d;
  logic [3:0] sync_timer_q, sync_timer_d;
  logic [`SLET_PEND_W-1:0] pending_q, pending_d;
  logic sync_out_q, sync_out_d;

  assign reg_idx = paddr[`SLET_ADDR_W-1:2];
  assign bus_access = psel && penable && pready_q;
  assign bus_write = bus_access && pwrite && addr_hit;

  // The mask is printed in the reverse order of the counter fields.
  assign mask_by_type = {sync_error_type_mask_q[0], sync_error_type_mask_q[1],
                         sync_error_type_mask_q[2]}; // RQ7
  assign auto_clear_by_type = {NT{auto_counter_clear_q}} & mask_by_type; // RQ11

  // One counter block per lane; lanes above 0 count every type.
  for (genvar l = 0; l < NL; l++) begin : g_lane
    slet_lane_counter u_lane (
      .pclk(pclk),
      .presetn(presetn),
      .hold_clear(link_soft_reset),
      .lane_active(lane_active[l]),
      .count_en((l == 0) ? lane0_counter_enables_q : `SLET_ALL_TYPES), // RQ9 RQ10
      .auto_clear(auto_clear_by_type),
      .threshold(error_threshold_q), // RQ5
      .lane_errors({unexpected_control_char_error[l], not_in_table_error[l],
                    bad_disparity_error[l]}),
      .match(lane_match[l*NT +: NT]),
      .at_limit(lane_at_limit[l*NT +: NT])
    );
  end

  // Fold lanes into per-type views and count new masked hits.
  always_comb begin
    type_match = '0;
    type_at_limit = '0;
    new_events = '0;
    for (int l = 0; l < NL; l++) begin
      type_match = type_match | lane_match[l*NT +: NT];
      type_at_limit = type_at_limit | lane_at_limit[l*NT +: NT];
      for (int t = 0; t < NT; t++) begin
        if (lane_match[l*NT + t] && mask_by_type[t]) begin // RQ8
          new_events = new_events + 8'h01;
        end
      end
    end
    // Merged reporting: a burst in one cycle counts as a single error.
    if (!queued_error_report_mode_q && (new_events != '0)) begin
      new_events = 8'h01; // RQ12
    end
  end

  // Read data mux; unmapped indices answer with an error, the write-only clear index reads zero.
  always_comb begin
    addr_hit = (paddr[1:0] == 2'h0);
    read_word = '0;
    case (reg_idx)
      `SLET_IDX_THRESH: read_word = 32'(error_threshold_q);
      `SLET_IDX_SYNC_MASK: read_word = 32'(sync_error_type_mask_q);
      `SLET_IDX_LANE0_CTRL: read_word = 32'(lane0_counter_enables_q) << `SLET_LANE0_EN_LSB;
      `SLET_IDX_ALIGN_MF: read_word = 32'(alignment_multiframe_count_q);
      `SLET_IDX_MODE: read_word = 32'({queued_error_report_mode_q, auto_counter_clear_q});
      `SLET_IDX_IRQ_STATUS: read_word = 32'(irq_status_q);
      `SLET_IDX_IRQ_CLEAR: read_word = '0;
      `SLET_IDX_IRQ_ENABLE: read_word = 32'(irq_enable_q);
      `SLET_IDX_SYNC_STATUS: read_word = 32'({type_at_limit, pending_q, sync_out_q});
      default: addr_hit = 1'b0;
    endcase
  end

  // Register writes, sticky status and the bus answer.
  always_comb begin
    error_threshold_d = error_threshold_q;
    sync_error_type_mask_d = sync_error_type_mask_q;
    lane0_counter_enables_d = lane0_counter_enables_q;
    alignment_multiframe_count_d = alignment_multiframe_count_q;
    auto_counter_clear_d = auto_counter_clear_q;
    queued_error_report_mode_d = queued_error_report_mode_q;
    irq_enable_d = irq_enable_q;
    irq_status_d = irq_status_q;
    if (bus_write) begin
      case (reg_idx)
        `SLET_IDX_THRESH: error_threshold_d = pwdata[7:0];
        `SLET_IDX_SYNC_MASK: sync_error_type_mask_d = pwdata[NT-1:0];
        `SLET_IDX_LANE0_CTRL: lane0_counter_enables_d = pwdata[`SLET_LANE0_EN_LSB +: NT];
        `SLET_IDX_ALIGN_MF: alignment_multiframe_count_d = pwdata[7:0];
        `SLET_IDX_MODE: begin
          auto_counter_clear_d = pwdata[`SLET_MODE_AUTO_CLR_BIT];
          queued_error_report_mode_d = pwdata[`SLET_MODE_QUEUE_BIT];
        end
        `SLET_IDX_IRQ_CLEAR: irq_status_d = irq_status_q & ~pwdata[`SLET_IRQ_W-1:0];
        `SLET_IDX_IRQ_ENABLE: irq_enable_d = pwdata[`SLET_IRQ_W-1:0];
        default: irq_status_d = irq_status_q;
      endcase
    end
    // Hardware sets after the clear so a same-cycle event is never lost.
    irq_status_d[NT-1:0] = irq_status_d[NT-1:0] | type_match; // RQ4
    irq_status_d[`SLET_IRQ_ILAS_BIT] = irq_status_d[`SLET_IRQ_ILAS_BIT] | ilas_done_q;
    irq_d = |(irq_status_d & irq_enable_d); // RQ4
    // Answer one cycle into the access phase; the master sees ready next edge.
    pready_d = psel && penable && !pready_q;
    prdata_d = (pready_d && !pwrite) ? read_word : '0;
    pslverr_d = pready_d && !addr_hit;
  end

  // Register file flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_threshold_q <= `SLET_RST_THRESH; // RQ3
      sync_error_type_mask_q <= `SLET_RST_SYNC_MASK; // RQ7
      lane0_counter_enables_q <= `SLET_RST_LANE0_EN; // RQ9
      alignment_multiframe_count_q <= `SLET_RST_ALIGN_MF;
      auto_counter_clear_q <= 1'b0;
      queued_error_report_mode_q <= 1'b0;
      irq_status_q <= '0;
      irq_enable_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      error_threshold_q <= error_threshold_d;
      sync_error_type_mask_q <= sync_error_type_mask_d;
      lane0_counter_enables_q <= lane0_counter_enables_d;
      alignment_multiframe_count_q <= alignment_multiframe_count_d;
      auto_counter_clear_q <= auto_counter_clear_d;
      queued_error_report_mode_q <= queued_error_report_mode_d;
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // Alignment span: four multiframes per programmed unit. An illegal count of
  // zero gives a zero span and the done pulse fires only when the 10-bit counter wraps, once per 1024 ticks.
  assign mf_span = 10'(alignment_multiframe_count_q) * `SLET_MF_PER_GROUP; // RQ2
  always_comb begin
    mf_count_d = mf_count_q;
    ilas_done_d = 1'b0;
    if (!ilas_active || link_soft_reset) begin
      mf_count_d = '0;
    end else if (multiframe_tick) begin
      if ((mf_count_q + 10'h001) == mf_span) begin
        mf_count_d = '0;
        ilas_done_d = 1'b1; // RQ2
      end else begin
        mf_count_d = mf_count_q + 10'h001;
      end
    end
  end

  // Alignment counter flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_count_q <= '0;
      ilas_done_q <= 1'b0;
    end else begin
      mf_count_q <= mf_count_d;
      ilas_done_q <= ilas_done_d;
    end
  end

  // Sequencer: trapped errors leave one after another as separate pulses.
  always_comb begin
    sync_state_d = sync_state_q;
    sync_timer_d = sync_timer_q;
    pending_d = pending_q;
    if (pending_q != '1) begin
      pending_d = (new_events > ~pending_q) ? '1 : pending_q + new_events; // RQ12
    end
    case (sync_state_q)
      slet_sync_idle: begin
        if (pending_q != '0) begin
          pending_d = pending_d - 8'h01;
          sync_state_d = slet_sync_assert; // RQ8
          sync_timer_d = `SLET_SYNC_ASSERT_CYCLES - 4'h1;
        end
      end
      slet_sync_assert: begin
        if (sync_timer_q == '0) begin
          sync_state_d = slet_sync_gap;
          sync_timer_d = `SLET_SYNC_GAP_CYCLES - 4'h1;
        end else begin
          sync_timer_d = sync_timer_q - 4'h1;
        end
      end
      slet_sync_gap: begin
        if (sync_timer_q == '0) begin
          sync_state_d = slet_sync_idle;
        end else begin
          sync_timer_d = sync_timer_q - 4'h1;
        end
      end
      default: sync_state_d = slet_sync_idle;
    endcase
    // Soft reset drops any queued requests so a restarted link starts clean.
    if (link_soft_reset) begin
      sync_state_d = slet_sync_idle;
      sync_timer_d = '0;
      pending_d = '0;
    end
    sync_out_d = (sync_state_d == slet_sync_assert);
  end

  // Sequencer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_state_q <= slet_sync_idle;
      sync_timer_q <= '0;
      pending_q <= '0;
      sync_out_q <= 1'b0;
    end else begin
      sync_state_q <= sync_state_d;
      sync_timer_q <= sync_timer_d;
      pending_q <= pending_d;
      sync_out_q <= sync_out_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sync_request_out = sync_out_q;
  assign ilas_done = ilas_done_q;
  assign irq = irq_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ilas_span: assert property ( // RQ2
    ilas_done_q |-> $past(mf_count_q) == mf_span - 10'h001)
    else $error("Alignment done fired at the wrong multiframe.");
  a_irq_on_match: assert property ( // RQ4
    type_match != '0 |=> (irq_status_q[NT-1:0] & $past(type_match)) == $past(type_match))
    else $error("Limit match did not set the status bit.");
  a_mask_reversed: assert property ( // RQ7
    (type_match == 3'h1) && (lane_match & ~{NL{3'h1}}) == '0 &&
    !sync_error_type_mask_q[2] |-> new_events == 8'h00)
    else $error("Disparity match escaped a cleared mask bit.");
  a_sync_needs_cause: assert property ( // RQ8
    sync_state_q == slet_sync_idle && pending_q == '0 && !link_soft_reset
    |=> !sync_request_out)
    else $error("Sync request rose with nothing pending.");
  a_lane0_enable: assert property ( // RQ9
    !lane0_counter_enables_q[0] |=> !lane_match[0])
    else $error("Disabled lane 0 disparity counter matched.");
  a_queue_merge: assert property ( // RQ12
    !queued_error_report_mode_q && lane_match != '0 && (lane_match & {NL{mask_by_type}}) != '0
    |-> new_events == 8'h01)
    else $error("Simultaneous errors were not merged.");
  // A soft reset may cut a pulse short, but nothing may stretch it past four cycles.
  a_sync_width: assert property ( // RQ12
    $rose(sync_request_out) |->
    (sync_request_out || link_soft_reset) [*4] ##1 !sync_request_out)
    else $error("Sync request pulse has the wrong width.");
  a_irq_level: assert property ( // RQ4
    irq |-> $past((irq_status_d & irq_enable_d) != '0))
    else $error("Interrupt high without an enabled status bit.");

  c_sync_pulse: cover property ($rose(sync_request_out));
  c_irq_rise: cover property ($rose(irq));
  c_ilas_done: cover property (ilas_done);
  c_back_to_back: cover property (sync_request_out ##5 !sync_request_out ##4 sync_request_out);

endmodule

// ---- src/slet_lane_counter.sv ----
`timescale 1ns/1ps
`include "slet_regs.svh"

module slet_lane_counter (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control from the link and the register file.
  input wire logic hold_clear,
  input wire logic lane_active,
  input wire logic [`SLET_NUM_TYPES-1:0] count_en,
  input wire logic [`SLET_NUM_TYPES-1:0] auto_clear,
  input wire slet_pkg::slet_count_type threshold,
  // Error strobes; bit 0 bad disparity, bit 1 not in table, bit 2 control char.
  input wire logic [`SLET_NUM_TYPES-1:0] lane_errors,
  // Results.
  output logic [`SLET_NUM_TYPES-1:0] match,
  output logic [`SLET_NUM_TYPES-1:0] at_limit
);
  import slet_pkg::*;

  slet_count_type count_q [`SLET_NUM_TYPES];
  slet_count_type count_d [`SLET_NUM_TYPES];
  logic [`SLET_NUM_TYPES-1:0] match_q;
  logic [`SLET_NUM_TYPES-1:0] match_d;

  // Counters stop at the limit so that a match fires exactly once per climb.
  always_comb begin
    for (int t = 0; t < `SLET_NUM_TYPES; t++) begin
      count_d[t] = count_q[t];
      match_d[t] = 1'b0;
      if (hold_clear) begin
        count_d[t] = '0;
      end else if (auto_clear[t] && (count_q[t] == threshold)) begin
        count_d[t] = '0; // RQ11
      end else if (lane_active && count_en[t] && lane_errors[t] &&
                   (count_q[t] != threshold)) begin // RQ5 RQ10
        count_d[t] = count_q[t] + 8'h01; // RQ3
        match_d[t] = (count_d[t] == threshold); // RQ3
      end
    end
  end

  // Counter and match registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < `SLET_NUM_TYPES; t++) begin
        count_q[t] <= '0;
      end
      match_q <= '0;
    end else begin
      count_q <= count_d;
      match_q <= match_d;
    end
  end

  assign match = match_q;

  // Level view of which counters rest at the limit.
  always_comb begin
    for (int t = 0; t < `SLET_NUM_TYPES; t++) begin
      at_limit[t] = (count_q[t] == threshold);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar t = 0; t < `SLET_NUM_TYPES; t++) begin : g_chk
    a_match_at_limit: assert property ( // RQ3
      match_q[t] |-> (count_q[t] == threshold) && (count_q[t] == $past(count_q[t]) + 8'h01))
      else $error("Match raised away from the limit.");
    a_disabled_holds: assert property ( // RQ10
      !count_en[t] && !hold_clear && !(auto_clear[t] && at_limit[t])
      |=> $stable(count_q[t]))
      else $error("Disabled counter moved.");
    a_auto_clears: assert property ( // RQ11
      auto_clear[t] && at_limit[t] |=> count_q[t] == 8'h00)
      else $error("Counter at limit was not auto cleared.");
    a_idle_lane_quiet: assert property ( // RQ5
      !lane_active |=> !match_q[t])
      else $error("Inactive lane reported a match.");
  end

endmodule

// ---- src/slet_pkg.sv ----
package slet_pkg;

  // Error counter value, compared against the shared limit.
  typedef logic [7:0] slet_count_type;

  // Sync request sequencer states.
  typedef enum logic [1:0] {
    slet_sync_idle = 2'b00,
    slet_sync_assert = 2'b01,
    slet_sync_gap = 2'b10
  } slet_sync_state_type;

endpackage

// ---- src/slet_regs.svh ----
`ifndef SLET_REGS_SVH
`define SLET_REGS_SVH

// Geometry.
`define SLET_NUM_LANES 8
`define SLET_NUM_TYPES 3
`define SLET_ADDR_W 13
`define SLET_IDX_W 11
`define SLET_IRQ_W 4
`define SLET_PEND_W 8

// Register indices; the byte address is four times the index.
`define SLET_IDX_THRESH 11'h47C
`define SLET_IDX_SYNC_MASK 11'h47D
`define SLET_IDX_LANE0_CTRL 11'h480
`define SLET_IDX_ALIGN_MF 11'h490
`define SLET_IDX_MODE 11'h491
`define SLET_IDX_IRQ_STATUS 11'h492
`define SLET_IDX_IRQ_CLEAR 11'h493
`define SLET_IDX_IRQ_ENABLE 11'h494
`define SLET_IDX_SYNC_STATUS 11'h495

// Field positions.
`define SLET_LANE0_EN_LSB 3
`define SLET_MODE_AUTO_CLR_BIT 0
`define SLET_MODE_QUEUE_BIT 1
`define SLET_IRQ_ILAS_BIT 3

// Reset values.
`define SLET_RST_THRESH 8'hFF
`define SLET_RST_SYNC_MASK 3'h7
`define SLET_RST_LANE0_EN 3'h7
`define SLET_RST_ALIGN_MF 8'h01
`define SLET_ALL_TYPES 3'h7

// Timing counts: multiframes per group, then sync pulse and gap in pclk cycles.
`define SLET_MF_PER_GROUP 10'h004
`define SLET_SYNC_ASSERT_CYCLES 4'h4
`define SLET_SYNC_GAP_CYCLES 4'h4

`endif

// ---- verif/slet_framer_model.sv ----
`timescale 1ns/1ps
// Stand-in for the transmitting framer: bench requests become error strobes and
// multiframe ticks are paced during alignment.
module slet_framer_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests.
  input wire logic [7:0] req_bd,
  input wire logic [7:0] req_nit,
  input wire logic [7:0] req_uek,
  input wire logic ilas_req,
  input wire logic [3:0] tick_gap,
  // Toward the monitor.
  output logic [7:0] bad_disparity_error,
  output logic [7:0] not_in_table_error,
  output logic [7:0] unexpected_control_char_error,
  output logic ilas_active,
  output logic multiframe_tick
);
  logic [3:0] gap_q;

  // One request is one strobe of one cycle, so one request is one error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {bad_disparity_error, not_in_table_error, unexpected_control_char_error} <= 24'h000000;
    end else begin
      {bad_disparity_error, not_in_table_error, unexpected_control_char_error} <=
        {req_bd, req_nit, req_uek};
    end
  end

  // A larger gap mimics a slow framer; the tick stays low outside alignment.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 4'h0;
      multiframe_tick <= 1'b0;
      ilas_active <= 1'b0;
    end else begin
      ilas_active <= ilas_req;
      multiframe_tick <= ilas_req && (gap_q >= tick_gap);
      gap_q <= (!ilas_req || gap_q >= tick_gap) ? 4'h0 : gap_q + 4'h1;
    end
  end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "slet_regs.svh"
module tb;
  import slet_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [`SLET_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, irq, ilas_done, ilas_active, mf_tick, sync_request_out;
  logic link_soft_reset = 1'b1, ilas_req = 1'b0, sync_prev = 1'b0;
  logic [7:0] lane_active = 8'hFF, req_bd = 8'h00, req_nit = 8'h00, req_uek = 8'h00;
  logic [7:0] bde, nite, ucce, lanes;
  logic [3:0] tick_gap = 4'h3;
  int err_total = 0, tests_run = 0, sync_pulses = 0, sync_high = 0, ticks = 0, done_at = 0;
  int thr, p0, h0, t0, n, ex;

  always #25 pclk = ~pclk;

  slet_error_monitor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_soft_reset(link_soft_reset), .lane_active(lane_active),
    .bad_disparity_error(bde), .not_in_table_error(nite),
    .unexpected_control_char_error(ucce), .ilas_active(ilas_active),
    .multiframe_tick(mf_tick), .sync_request_out(sync_request_out),
    .ilas_done(ilas_done), .irq(irq));

  slet_framer_model far_u (.pclk(pclk), .presetn(presetn), .req_bd(req_bd),
    .req_nit(req_nit), .req_uek(req_uek), .ilas_req(ilas_req), .tick_gap(tick_gap),
    .bad_disparity_error(bde), .not_in_table_error(nite),
    .unexpected_control_char_error(ucce), .ilas_active(ilas_active),
    .multiframe_tick(mf_tick));

  // Tallies of sync pulses, their width and alignment ticks; scenarios compare deltas.
  always @(posedge pclk) begin
    if (sync_request_out === 1'b1 && sync_prev !== 1'b1) sync_pulses++;
    if (sync_request_out === 1'b1) sync_high++;
    if (mf_tick === 1'b1) ticks++;
    if (ilas_done === 1'b1) done_at = ticks;
    sync_prev = sync_request_out;
  end

  // Sync mask bits run opposite to the counter type order.
  function automatic logic [7:0] mask_of(input int t);
    return 8'h04 >> t;
  endfunction

  // Without queued mode a burst of simultaneous matches is reported once.
  function automatic int sync_expect(input int queued, input logic [7:0] l);
    return queued ? $countones(l) : 1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [`SLET_IDX_W-1:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic rdc(input logic [`SLET_IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // Configuration changes only while the link is held in soft reset.
  task automatic setup(input logic [7:0] th, input logic [7:0] mk, input logic [7:0] md,
                       input logic [7:0] en0, input logic [7:0] mf);
    @(posedge pclk);
    link_soft_reset <= 1'b1;
    apb(1'b1, `SLET_IDX_THRESH, {24'h0, th});
    apb(1'b1, `SLET_IDX_SYNC_MASK, {24'h0, mk});
    apb(1'b1, `SLET_IDX_LANE0_CTRL, {24'h0, en0});
    apb(1'b1, `SLET_IDX_MODE, {24'h0, md});
    apb(1'b1, `SLET_IDX_ALIGN_MF, {24'h0, mf});
    apb(1'b1, `SLET_IDX_IRQ_ENABLE, 32'hF);
    apb(1'b1, `SLET_IDX_IRQ_CLEAR, 32'hF);
    @(posedge pclk);
    link_soft_reset <= 1'b0;
  endtask

  // Type 0 disparity, 1 table, 2 control character; each round is one error per lane.
  task automatic hit(input int t, input logic [7:0] l, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      req_bd <= (t == 0) ? l : 8'h00;
      req_nit <= (t == 1) ? l : 8'h00;
      req_uek <= (t == 2) ? l : 8'h00;
      @(posedge pclk);
      {req_bd, req_nit, req_uek} <= 24'h000000;
    end
    repeat (40) @(posedge pclk);
  endtask

  // The watchdog allows over twenty times the expected run length.
  initial begin
    #2000000;
    err_total++;
    summarize();
  end

  initial begin
    void'($urandom(4));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`SLET_IDX_THRESH, 32'hFF);
    rdc(`SLET_IDX_SYNC_MASK, 32'h7);
    rdc(`SLET_IDX_LANE0_CTRL, 32'h38);
    rdc(`SLET_IDX_ALIGN_MF, 32'h1);
    rdc(`SLET_IDX_IRQ_STATUS, 32'h0);
    apb(1'b0, 11'h7FF, 32'h0);
    chk({31'h0, se}, 32'h1);
    // Each type alone in the mask: another type at the limit must not raise sync.
    for (int t = 0; t < 3; t++) begin
      thr = $urandom_range(2, 5);
      lanes = 8'h01 << $urandom_range(1, 7);
      setup(thr[7:0], mask_of(t), 8'h00, 8'h38, 8'h01);
      rdc(`SLET_IDX_THRESH, thr);
      p0 = sync_pulses;
      hit((t + 1) % 3, lanes, thr);
      chk(32'(sync_pulses - p0), 32'h0);
      rdc(`SLET_IDX_IRQ_STATUS, 32'h1 << ((t + 1) % 3));
      chk({31'h0, irq}, 32'h1);
      hit(t, lanes, thr - 1);
      chk(32'(sync_pulses - p0), 32'h0);
      hit(t, lanes, 1);
      chk(32'(sync_pulses - p0), 32'h1);
    end
    apb(1'b1, `SLET_IDX_IRQ_ENABLE, 32'h0);
    // The write lands on the edge that ends the transfer; look one edge later.
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SLET_IDX_IRQ_CLEAR, 32'hF);
    rdc(`SLET_IDX_IRQ_STATUS, 32'h0);
    // Simultaneous matches on several lanes, merged and then queued.
    for (int q = 0; q < 2; q++) begin
      lanes = $urandom_range(2, 255);
      setup(8'h01, 8'h07, q[0] << 1, 8'h38, 8'h01);
      p0 = sync_pulses;
      h0 = sync_high;
      hit(0, lanes, 1);
      repeat (60) @(posedge pclk);
      ex = sync_expect(q, lanes);
      chk(32'(sync_pulses - p0), 32'(ex));
      chk(32'(sync_high - h0), 32'(ex * `SLET_SYNC_ASSERT_CYCLES));
    end
    // A disabled lane 0 counter and an inactive lane stay quiet; another lane counts.
    n = $urandom_range(0, 2);
    setup(8'h02, 8'h07, 8'h00, 8'h38 ^ (8'h08 << n), 8'h01);
    rdc(`SLET_IDX_LANE0_CTRL, 32'h38 ^ (32'h08 << n));
    hit(n, 8'h01, 3);
    rdc(`SLET_IDX_IRQ_STATUS, 32'h0);
    lane_active <= 8'hFD;
    hit(n, 8'h02, 3);
    rdc(`SLET_IDX_IRQ_STATUS, 32'h0);
    hit(n, 8'h04, 2);
    rdc(`SLET_IDX_IRQ_STATUS, 32'h1 << n);
    lane_active <= 8'hFF;
    // Auto clear zeroes only the counter that raised sync.
    for (int a = 0; a < 2; a++) begin
      setup(8'h02, 8'h07, a[7:0], 8'h38, 8'h01);
      p0 = sync_pulses;
      hit(1, 8'h10, 1);
      hit(0, 8'h10, 2);
      apb(1'b0, `SLET_IDX_SYNC_STATUS, 32'h0);
      chk({29'h0, rd[11:9]}, a ? 32'h0 : 32'h1);
      hit(0, 8'h10, 2);
      hit(1, 8'h10, 1);
      chk(32'(sync_pulses - p0), a ? 32'h3 : 32'h2);
    end
    // Alignment spans four multiframes per programmed group, fast and slow framer.
    for (int k = 1; k <= 4; k = k * 2) begin
      setup(8'hFF, 8'h07, 8'h00, 8'h38, k[7:0]);
      @(posedge pclk);
      tick_gap <= 4'($urandom_range(1, 6));
      ilas_req <= 1'b1;
      t0 = ticks;
      done_at = -1;
      n = 0;
      while (done_at < 0 && n < 600) begin
        @(posedge pclk);
        n++;
      end
      ilas_req <= 1'b0;
      chk(32'(done_at - t0), 32'(4 * k));
    end
    // A second reset in mid-run brings the limit back to its reset value.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`SLET_IDX_THRESH, 32'hFF);
    rdc(`SLET_IDX_ALIGN_MF, 32'h1);
    rdc(`SLET_IDX_IRQ_ENABLE, 32'h0);
    summarize();
  end
endmodule
